// >>> rtl/cmg_pkg.sv
// Package for the codec mixing, ADC gain and interrupt register slice.
// Assumes a 32-bit classic Wishbone slave where each register sits in the low byte of one word.
package cmg_pkg;

   // ------------------------------------------------------------------
   // Register indices; the byte address is four times the index.
   // ------------------------------------------------------------------
   localparam logic [5:0] IDX_LEVEL_STYLE  = 6'h0D;
   localparam logic [5:0] IDX_MIX_PAIR0    = 6'h18;
   localparam logic [5:0] IDX_ADC_LEFT     = 6'h1C;
   localparam logic [5:0] IDX_ADC_RIGHT    = 6'h1D;
   localparam logic [5:0] IDX_IRQ_PORT_CTL = 6'h1E;
   localparam logic [5:0] IDX_IRQ_FLAGS    = 6'h20;
   localparam logic [5:0] IDX_IRQ_UNMASK   = 6'h21;
   localparam logic [5:0] IDX_IRQ_MODE_HI  = 6'h22;
   localparam logic [5:0] IDX_IRQ_MODE_LO  = 6'h23;
   localparam logic [5:0] IDX_PLL_FORCE    = 6'h30;

   // ------------------------------------------------------------------
   // Field positions and reset values.
   // ------------------------------------------------------------------
   localparam int         STYLE_LSB        = 4;
   localparam int         ALIGN_BIT        = 7;
   localparam int         DEEMPH_LSB       = 4;
   localparam int         PIN_STYLE_LSB    = 2;
   localparam int         UNLOCK_BIT       = 7;
   localparam int         OVERRANGE_BIT    = 1;
   localparam logic [4:0] MIX_RESET        = 5'h09;
   localparam logic [7:0] BYTE_RESET       = 8'h00;
   localparam logic [7:0] IRQ_IMPL_MASK    = 8'h82;

   // ------------------------------------------------------------------
   // Timing count in frame-clock periods, and ramp step in eighths of a dB.
   // ------------------------------------------------------------------
   localparam logic [9:0] ZC_TIMEOUT_FRAMES = 10'h200;
   localparam logic [8:0] RAMP_STEP_EIGHTHS = 9'h001;

   typedef enum logic [1:0] {
      STYLE_IMMEDIATE = 2'h0,
      STYLE_ZERO_CROSS = 2'h1,
      STYLE_RAMP = 2'h2,
      STYLE_RAMP_ZC = 2'h3
   } cmg_style_e;

   typedef enum logic [1:0] {
      IRQ_RISE = 2'h0,
      IRQ_FALL = 2'h1,
      IRQ_LEVEL = 2'h2,
      IRQ_RSVD = 2'h3
   } cmg_irq_mode_e;

   typedef enum logic [1:0] {
      PIN_HIGH = 2'h0,
      PIN_LOW = 2'h1,
      PIN_OPEN_DRAIN = 2'h2,
      PIN_RSVD = 2'h3
   } cmg_pin_e;

endpackage : cmg_pkg

// >>> rtl/cmg_mix_pair.sv
// Channel-mixing decode for one output pair, purely combinational.
// Assumes the caller registers the results on the frame tick.
`timescale 1ns/1ps
module cmg_mix_pair
   import cmg_pkg::*;
(
   input  wire logic [4:0]  pair_mix_select,
   input  wire logic [23:0] a_left,
   input  wire logic [23:0] a_right,
   input  wire logic [23:0] b_left,
   input  wire logic [23:0] b_right,
   output logic [23:0]      pair_out_first,
   output logic [23:0]      pair_out_second
);
   // ------------------------------------------------------------------
   // Averages.
   // ------------------------------------------------------------------
   // full-precision halving. A 25-bit sum keeps the carry, so no overflow.
   wire logic signed [24:0] sum_a  = $signed({a_left[23], a_left}) + $signed({a_right[23], a_right});
   wire logic signed [24:0] sum_b  = $signed({b_left[23], b_left}) + $signed({b_right[23], b_right});
   wire logic signed [24:0] sum_x1 = $signed({a_left[23], a_left}) + $signed({b_right[23], b_right});
   wire logic signed [24:0] sum_x2 = $signed({b_left[23], b_left}) + $signed({a_right[23], a_right});
   wire logic [23:0] avg_a  = sum_a[24:1];
   wire logic [23:0] avg_b  = sum_b[24:1];
   wire logic [23:0] avg_x1 = sum_x1[24:1];
   wire logic [23:0] avg_x2 = sum_x2[24:1];

   // cross averages: code 11110 on the first output and 10111 on the second use bL+aR.
   wire logic [23:0] cross_first  = (pair_mix_select[1:0] == 2'h2) ? avg_x2 : avg_x1;
   wire logic [23:0] cross_second = (pair_mix_select[3:2] == 2'h1) ? avg_x2 : avg_x1;
   wire logic [23:0] mean_first   = pair_mix_select[4] ? cross_first : avg_a;
   wire logic [23:0] mean_second  = pair_mix_select[4] ? cross_second : avg_b;

   // source decode: 00 mute, 01 right, 10 left, 11 average.
   assign pair_out_first = (pair_mix_select[3:2] == 2'h0) ? 24'h000000 :
                           (pair_mix_select[3:2] == 2'h1) ? a_right :
                           (pair_mix_select[3:2] == 2'h2) ? a_left : mean_first;
   assign pair_out_second = (pair_mix_select[1:0] == 2'h0) ? 24'h000000 :
                            (pair_mix_select[1:0] == 2'h1) ? b_right :
                            (pair_mix_select[1:0] == 2'h2) ? b_left : mean_second;
endmodule : cmg_mix_pair

// >>> rtl/cmg_gain_ramp.sv
// Level-change engine for one ADC gain channel, in 1/8 dB units.
// Assumes frame_tick is a one-cycle pulse per frame and zero_cross is valid on it.
`timescale 1ns/1ps
module cmg_gain_ramp
   import cmg_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic [5:0]  target_db,
   input  wire logic [1:0]  level_change_style,
   input  wire logic        frame_tick,
   input  wire logic        zero_cross,
   output logic [8:0]       level
);
   logic [9:0] wait_cnt;

   // Target in eighths of a dB, the 6-bit field shifted left by three.
   wire logic [8:0] goal      = {target_db, 3'h0};
   wire logic       at_goal   = (level == goal);
   wire logic       going_up  = ($signed(level) < $signed(goal));
   wire logic [8:0] step_lvl  = going_up ? level + RAMP_STEP_EIGHTHS : level - RAMP_STEP_EIGHTHS;
   // a missing crossing gives way after 512 frames, inside the 512 to 1024 window.
   wire logic       timed_out = (wait_cnt == ZC_TIMEOUT_FRAMES - 10'h001);
   wire logic       zc_ok     = zero_cross | timed_out;
   wire cmg_style_e style     = cmg_style_e'(level_change_style);

   // the style picks how a new gain reaches the signal.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         level    <= 9'h000;
         wait_cnt <= 10'h000;
      end else if (at_goal) begin
         wait_cnt <= 10'h000;
      end else begin
         unique case (style)
            STYLE_IMMEDIATE: level <= goal;
            STYLE_ZERO_CROSS: if (frame_tick) begin
               level    <= zc_ok ? goal : level;
               wait_cnt <= zc_ok ? 10'h000 : wait_cnt + 10'h001;
            end
            // ramp steps 1/8 dB per frame, which is 1 dB per 8 frames.
            STYLE_RAMP: if (frame_tick) begin
               level <= step_lvl;
            end
            STYLE_RAMP_ZC: if (frame_tick) begin
               level    <= zc_ok ? step_lvl : level;
               wait_cnt <= zc_ok ? 10'h000 : wait_cnt + 10'h001;
            end
         endcase
      end
   end
endmodule : cmg_gain_ramp

// >>> rtl/cmg_regs.sv
// Register bank for pair mixing, ADC gain, port control and interrupt status.
// Assumes a classic Wishbone master on core_clk and audio samples valid on frame_tick.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps

// Behaviour
// - Each pair has a 5-bit mixing select, reset to 01001.
// - Select bits 3:2 pick first output, 1:0 second: mute, right, left, average.
// - With bit 4 set, averages become cross averages per code.
// - Gain fields are 6-bit two's complement, 1 dB steps, reset zero.
// - Gain changes follow the selected level-change style.
// - Align bit forces DAC and ADC port clocks in phase; reset zero.
// - De-emphasis select 01/10/11 picks 32/44.1/48 kHz under forced lock.
// - Pin style: 00 high, 01 low, 10 open-drain low; 11 reserved.
// - A status bit reads 1 if its event happened since the last read.
// - Reading status returns flags then clears them all.
// - A masked flag reads zero and its event neither sets nor signals.
// - Status bit 7 is PLL unlock, reset zero.
// - Status bit 1 is ADC over-range on either channel.
// - Unmask bit 1 lets the source flag and signal; resets to zero.
// - Unmask bits sit at the status positions, 7 and 1.
// - Per-source mode: 00 arrival, 01 removal, 10 while present.
// - Zero-cross change waits for a crossing, else 512 to 1024 frames.
// - Soft ramp moves 1/8 dB at a time, 1 dB per 8 frames.
module cmg_regs
   import cmg_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        frame_tick,
   input  wire logic [95:0] a_left,
   input  wire logic [95:0] a_right,
   input  wire logic [95:0] b_left,
   input  wire logic [95:0] b_right,
   output logic [95:0]      pair_out_first,
   output logic [95:0]      pair_out_second,
   input  wire logic        left_zero_cross,
   input  wire logic        right_zero_cross,
   output logic [8:0]       left_adc_gain,
   output logic [8:0]       right_adc_gain,
   output logic             serial_port_align,
   output logic [1:0]       deemph_active,
   input  wire logic        pll_unlocked,
   input  wire logic        adc_overrange_left,
   input  wire logic        adc_overrange_right,
   output logic             irq_out,
   output logic             irq_oe
);
   // ------------------------------------------------------------------
   // Storage.
   // ------------------------------------------------------------------
   logic [4:0] pair_mix_select [4];
   logic [5:0] left_gain_field;
   logic [5:0] right_gain_field;
   logic [1:0] level_change_style;
   logic [7:0] ctl_byte;
   logic [7:0] irq_flags;
   logic [7:0] irq_unmask;
   logic [7:0] mode_hi;
   logic [7:0] mode_lo;
   logic       force_pll_lock;
   logic [1:0] src_prev;

   // ------------------------------------------------------------------
   // Bus decode.
   // ------------------------------------------------------------------
   // One-cycle answer: a request is taken when no ack is pending.
   wire logic       bus_take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire logic [5:0] idx      = wb_adr_i[7:2];
   wire logic       wr_en    = bus_take & wb_we_i & wb_sel_i[0];
   wire logic [7:0] wbyte    = wb_dat_i[7:0];
   wire logic       is_mix   = (idx[5:2] == IDX_MIX_PAIR0[5:2]);
   wire logic       rd_flags = bus_take & ~wb_we_i & (idx == IDX_IRQ_FLAGS);

   // masked flags always read as zero.
   wire logic [7:0] flags_view = irq_flags & irq_unmask;

   // Read value; unmapped indices and reserved bits read zero.
   wire logic [7:0] rd_byte =
      is_mix                      ? {3'h0, pair_mix_select[idx[1:0]]} :
      (idx == IDX_LEVEL_STYLE)    ? {2'h0, level_change_style, 4'h0} :
      (idx == IDX_ADC_LEFT)       ? {2'h0, left_gain_field} :
      (idx == IDX_ADC_RIGHT)      ? {2'h0, right_gain_field} :
      (idx == IDX_IRQ_PORT_CTL)   ? ctl_byte :
      (idx == IDX_IRQ_FLAGS)      ? flags_view :
      (idx == IDX_IRQ_UNMASK)     ? irq_unmask :
      (idx == IDX_IRQ_MODE_HI)    ? mode_hi :
      (idx == IDX_IRQ_MODE_LO)    ? mode_lo :
      (idx == IDX_PLL_FORCE)      ? {7'h00, force_pll_lock} : BYTE_RESET;

   // Acknowledge and read data capture.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_take;
         wb_dat_o <= bus_take ? {24'h000000, rd_byte} : wb_dat_o;
      end
   end

   // ------------------------------------------------------------------
   // Control registers.
   // ------------------------------------------------------------------
   // mixing selects, per pair, reset 01001.
   always_ff @(posedge core_clk) begin
      for (int p = 0; p < 4; p++) begin
         if (sys_rst) begin
            pair_mix_select[p] <= MIX_RESET;
         end else if (wr_en && is_mix && idx[1:0] == 2'(p)) begin
            pair_mix_select[p] <= wbyte[4:0];
         end
      end
   end

   // gain fields keep six bits; reserved bits are dropped.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         left_gain_field    <= 6'h00;
         right_gain_field   <= 6'h00;
         level_change_style <= 2'h0;
         ctl_byte           <= BYTE_RESET;
         irq_unmask         <= BYTE_RESET;
         mode_hi            <= BYTE_RESET;
         mode_lo            <= BYTE_RESET;
         force_pll_lock     <= 1'b0;
      end else if (wr_en) begin
         if (idx == IDX_ADC_LEFT) left_gain_field <= wbyte[5:0];
         if (idx == IDX_ADC_RIGHT) right_gain_field <= wbyte[5:0];
         if (idx == IDX_LEVEL_STYLE) level_change_style <= wbyte[STYLE_LSB +: 2];
         // Bits 6, 1 and 0 of the control byte are reserved and stay zero.
         if (idx == IDX_IRQ_PORT_CTL) ctl_byte <= wbyte & 8'hBC;
         // only bits 7 and 1 exist in the unmask and mode registers.
         if (idx == IDX_IRQ_UNMASK) irq_unmask <= wbyte & IRQ_IMPL_MASK;
         if (idx == IDX_IRQ_MODE_HI) mode_hi <= wbyte & IRQ_IMPL_MASK;
         if (idx == IDX_IRQ_MODE_LO) mode_lo <= wbyte & IRQ_IMPL_MASK;
         if (idx == IDX_PLL_FORCE) force_pll_lock <= wbyte[0];
      end
   end

   // ------------------------------------------------------------------
   // Mixing datapath.
   // ------------------------------------------------------------------
   logic [95:0] dec_first;
   logic [95:0] dec_second;

   for (genvar p = 0; p < 4; p++) begin : g_pair
      cmg_mix_pair u_mix (
         .pair_mix_select (pair_mix_select[p]),
         .a_left          (a_left[24*p +: 24]),
         .a_right         (a_right[24*p +: 24]),
         .b_left          (b_left[24*p +: 24]),
         .b_right         (b_right[24*p +: 24]),
         .pair_out_first  (dec_first[24*p +: 24]),
         .pair_out_second (dec_second[24*p +: 24])
      );
   end

   // outputs update once per frame so a pair never changes mid-sample.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pair_out_first  <= 96'h0;
         pair_out_second <= 96'h0;
      end else if (frame_tick) begin
         pair_out_first  <= dec_first;
         pair_out_second <= dec_second;
      end
   end

   // ------------------------------------------------------------------
   // ADC gain engines.
   // ------------------------------------------------------------------
   // both channels share the style but cross zero independently.
   cmg_gain_ramp u_left (
      .core_clk           (core_clk),
      .sys_rst            (sys_rst),
      .target_db          (left_gain_field),
      .level_change_style (level_change_style),
      .frame_tick         (frame_tick),
      .zero_cross         (left_zero_cross),
      .level              (left_adc_gain)
   );

   cmg_gain_ramp u_right (
      .core_clk           (core_clk),
      .sys_rst            (sys_rst),
      .target_db          (right_gain_field),
      .level_change_style (level_change_style),
      .frame_tick         (frame_tick),
      .zero_cross         (right_zero_cross),
      .level              (right_adc_gain)
   );

   // ------------------------------------------------------------------
   // Port alignment and de-emphasis.
   // ------------------------------------------------------------------
   // align output mirrors the control bit.
   // de-emphasis only applies while lock is forced; 00 means none.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         serial_port_align <= 1'b0;
         deemph_active     <= 2'h0;
      end else begin
         serial_port_align <= ctl_byte[ALIGN_BIT];
         deemph_active     <= force_pll_lock ? ctl_byte[DEEMPH_LSB +: 2] : 2'h0;
      end
   end

   // ------------------------------------------------------------------
   // Interrupt sources.
   // ------------------------------------------------------------------
   // over-range on either channel counts as one source.
   wire logic [1:0] src_now = {pll_unlocked, adc_overrange_left | adc_overrange_right};
   wire logic [1:0] src_on  = {irq_unmask[UNLOCK_BIT], irq_unmask[OVERRANGE_BIT]};
   wire cmg_irq_mode_e unlock_irq_mode =
      cmg_irq_mode_e'({mode_hi[UNLOCK_BIT], mode_lo[UNLOCK_BIT]});
   wire cmg_irq_mode_e overrange_irq_mode =
      cmg_irq_mode_e'({mode_hi[OVERRANGE_BIT], mode_lo[OVERRANGE_BIT]});

   // edge or level qualification per source; reserved mode never fires.
   function automatic logic qualify(input cmg_irq_mode_e m, input logic now, input logic prev);
      qualify = (m == IRQ_RISE) ? (now & ~prev) :
                (m == IRQ_FALL) ? (~now & prev) :
                (m == IRQ_LEVEL) ? now : 1'b0;
   endfunction : qualify

   // an event only counts when its unmask bit is set.
   wire logic [1:0] src_event = src_on & {qualify(unlock_irq_mode, src_now[1], src_prev[1]),
                                          qualify(overrange_irq_mode, src_now[0], src_prev[0])};
   wire logic [7:0] set_vec   = {src_event[1], 5'h00, src_event[0], 1'b0};
   wire logic [7:0] next_flags = (rd_flags ? 8'h00 : irq_flags) | set_vec;

   // sticky flags; a status read clears, but a same-cycle event wins.
   // PLL unlock sits in bit 7 and resets to zero.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irq_flags <= BYTE_RESET;
         src_prev  <= 2'h0;
      end else begin
         irq_flags <= next_flags;
         src_prev  <= src_now;
      end
   end

   // ------------------------------------------------------------------
   // Interrupt pin.
   // ------------------------------------------------------------------
   // active while an unmasked flag stands or a level source persists.
   wire logic     irq_active = |(irq_flags & irq_unmask) | (|src_event);
   wire cmg_pin_e irq_pin_style = cmg_pin_e'(ctl_byte[PIN_STYLE_LSB +: 2]);

   // pin styling; the reserved code behaves as active high.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irq_out <= 1'b0;
         irq_oe  <= 1'b1;
      end else begin
         irq_out <= (irq_pin_style == PIN_LOW) ? ~irq_active :
                    (irq_pin_style == PIN_OPEN_DRAIN) ? 1'b0 : irq_active;
         irq_oe  <= (irq_pin_style == PIN_OPEN_DRAIN) ? irq_active : 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_status_read;
      rd_flags ##1 wb_ack_o;
   endsequence

   chk_mix_reset_value: assert property ($fell(sys_rst) |-> pair_mix_select[0] == 5'h09)
      else $error("mix select not 01001 after reset");
   chk_mix_output_path: assert property (frame_tick |=> pair_out_second == $past(dec_second))
      else $error("pair output does not follow decode");
   chk_cross_average: assert property ((pair_mix_select[0] == 5'h1C) |->
      dec_first[23:0] == 24'(($signed({a_left[23], a_left[23:0]})
                          + $signed({b_right[23], b_right[23:0]})) >>> 1))
      else $error("cross average wrong");
   // A write lands one edge before the level can follow, so the field must hold for two cycles.
   chk_gain_immediate: assert property (
      (level_change_style == 2'h0) && $stable(left_gain_field)
      ##1 (level_change_style == 2'h0) && $stable(left_gain_field)
      |-> left_adc_gain == {left_gain_field, 3'h0})
      else $error("immediate gain not applied");
   chk_align_follows: assert property (##1 serial_port_align == $past(ctl_byte[ALIGN_BIT]))
      else $error("align output lags");
   chk_deemph_gated: assert property (!$past(force_pll_lock) |-> deemph_active == 2'h0)
      else $error("de-emphasis active without forced lock");
   chk_pin_low_style: assert property ((irq_pin_style == PIN_LOW) |=> irq_oe
      && irq_out == !$past(irq_active))
      else $error("active-low pin wrong");
   chk_flag_clear_read: assert property (s_status_read |-> wb_dat_o[7:0] == $past(flags_view)
      && (irq_flags & ~$past(set_vec)) == 8'h00)
      else $error("status read did not clear");
   chk_masked_flag: assert property (!irq_unmask[OVERRANGE_BIT] |=> !$rose(irq_flags[1]))
      else $error("masked flag set");
   chk_unlock_sets: assert property (src_event[1] |=> irq_flags[UNLOCK_BIT])
      else $error("unlock event lost");
   chk_unmask_reset: assert property ($fell(sys_rst) |-> irq_unmask == 8'h00)
      else $error("unmask not zero after reset");
   chk_irq_on_event: assert property (src_event != 2'h0 && irq_pin_style == PIN_HIGH
      |=> irq_out)
      else $error("interrupt pin not asserted");

endmodule : cmg_regs

// >>> verif/cmg_host_model.sv
// Host model: control software issuing classic Wishbone cycles.
// Assumes a slave on core_clk that answers each request with ack.
`timescale 1ns/1ps
module cmg_host_model (
   input  wire logic        core_clk,
   input  wire logic        wb_ack_o,
   input  wire logic [31:0] wb_dat_o,
   output logic             wb_cyc_i,
   output logic             wb_stb_i,
   output logic             wb_we_i,
   output logic [7:0]       wb_adr_i,
   output logic [3:0]       wb_sel_i,
   output logic [31:0]      wb_dat_i
);
   // Idle bus at time zero.
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
      {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
   end
   // One cycle; released lines flip so stale values never look valid.
   // The request waits for ack however long it takes; only the bench watchdog ends a hang.
   task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge core_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
      {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, 4'hF, 24'h0, d};
      do begin
         @(posedge core_clk);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o[7:0];
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
      {wb_adr_i, wb_dat_i} <= {~a, 24'h0, ~d};
   endtask : xfer
endmodule : cmg_host_model

// >>> verif/test_codec_mix_gain_irq_regs.sv
// Self-checking bench for the mixing, gain and interrupt registers.
// Assumes cmg_pkg is compiled first; zero-cross inputs stay low.
`timescale 1ns/1ps
module test_codec_mix_gain_irq_regs;
   import cmg_pkg::*;
   logic core_clk = 0, sys_rst = 1, frame_tick = 0, left_zero_cross = 0, right_zero_cross = 0;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, serial_port_align, irq_out, irq_oe;
   logic pll_unlocked = 0, adc_overrange_left = 0, adc_overrange_right = 0;
   logic [95:0] a_left = 0, a_right = 0, b_left = 0, b_right = 0;
   logic [95:0] pair_out_first, pair_out_second;
   logic [31:0] wb_dat_i, wb_dat_o, seed = 32'h417B;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [8:0]  left_adc_gain, right_adc_gain;
   logic [1:0]  deemph_active;
   int          fails = 0, total_checks = 0, ea, eb;
   cmg_regs dut_u (.core_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .frame_tick, .a_left, .a_right, .b_left, .b_right,
      .pair_out_first, .pair_out_second, .left_zero_cross, .right_zero_cross, .left_adc_gain,
      .right_adc_gain, .serial_port_align, .deemph_active, .pll_unlocked, .adc_overrange_left,
      .adc_overrange_right, .irq_out, .irq_oe);
   cmg_host_model host_u (.core_clk, .wb_ack_o, .wb_dat_o, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i);
   // Clock at 10 MHz.
   initial forever #50 core_clk = ~core_clk;
   task automatic chk(input logic [31:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [5:0] i, input logic [7:0] d);
      logic [7:0] q;
      host_u.xfer(1'b1, {i, 2'h0}, d, q);
   endtask : wr
   task automatic rd(input logic [5:0] i, input logic [7:0] e);
      logic [7:0] q;
      host_u.xfer(1'b0, {i, 2'h0}, 8'h00, q);
      chk({24'h0, q}, {24'h0, e});
   endtask : rd
   // Raise the chosen conditions for two cycles, then drop them.
   task automatic pulse(input logic [2:0] m);
      @(posedge core_clk);
      {pll_unlocked, adc_overrange_left, adc_overrange_right} <= m;
      repeat (2) @(posedge core_clk);
      {pll_unlocked, adc_overrange_left, adc_overrange_right} <= 3'h0;
      @(negedge core_clk);
   endtask : pulse
   function automatic logic [23:0] rnd();
      repeat (24) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[23:0];
   endfunction : rnd
   // Halving by arithmetic shift of the full sum cannot overflow.
   function automatic int av(input int x, y);
      return (x + y) >>> 1;
   endfunction : av
   task automatic frame(input logic [4:0] c);
      int al, ar, bl, br;
      @(posedge core_clk);
      {a_left, a_right} <= {{4{rnd()}}, {4{rnd()}}};
      {b_left, b_right, frame_tick} <= {{4{rnd()}}, {4{rnd()}}, 1'b1};
      @(posedge core_clk);
      frame_tick <= 1'b0;
      @(negedge core_clk);
      {al, ar} = {32'($signed(a_left[23:0])), 32'($signed(a_right[23:0]))};
      {bl, br} = {32'($signed(b_left[23:0])), 32'($signed(b_right[23:0]))};
      ea = c[3:2] == 0 ? 0 : c[3:2] == 1 ? ar : c[3:2] == 2 ? al : !c[4] ? av(al, ar) :
         c[1:0] == 2 ? av(bl, ar) : av(al, br);
      eb = c[1:0] == 0 ? 0 : c[1:0] == 1 ? br : c[1:0] == 2 ? bl : !c[4] ? av(bl, br) :
         c[3:2] == 1 ? av(bl, ar) : av(al, br);
   endtask : frame
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   // Watchdog cuts a hang well past the expected run.
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      report_and_stop;
   end
   initial begin
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(IDX_MIX_PAIR0, 8'h09);
      rd(IDX_IRQ_UNMASK, 8'h00);
      rd(6'h3F, 8'h00);
      wr(IDX_ADC_LEFT, 8'hF1);
      rd(IDX_ADC_LEFT, 8'h31);
      wr(IDX_IRQ_PORT_CTL, 8'h80);
      @(negedge core_clk);
      chk(32'(serial_port_align), 32'h1);
      wr(IDX_PLL_FORCE, 8'h01);
      for (int d = 0; d < 4; d++) begin
         wr(IDX_IRQ_PORT_CTL, 8'(d << 4));
         @(negedge core_clk);
         chk(32'(deemph_active), 32'(d));
      end
      $display("register tests done");
      for (int c = 0; c < 32; c++) begin
         wr(IDX_MIX_PAIR0, 8'(c));
         frame(5'(c));
         chk(32'(pair_out_first[23:0]), 32'(ea[23:0]));
         chk(32'(pair_out_second[23:0]), 32'(eb[23:0]));
      end
      chk(32'(left_adc_gain), 32'h188);
      chk(32'(right_adc_gain), 32'h000);
      wr(IDX_LEVEL_STYLE, 8'h20);
      wr(IDX_ADC_LEFT, 8'h32);
      repeat (7) frame(5'h09);
      chk(32'(left_adc_gain), 32'h18F);
      frame(5'h09);
      chk(32'(left_adc_gain), 32'h190);
      wr(IDX_LEVEL_STYLE, 8'h10);
      wr(IDX_ADC_LEFT, 8'h31);
      repeat (511) frame(5'h09);
      chk(32'(left_adc_gain), 32'h190);
      frame(5'h09);
      chk(32'(left_adc_gain), 32'h188);
      $display("mixing tests done");
      wr(IDX_IRQ_UNMASK, 8'h82);
      pulse(3'h4);
      chk(32'(irq_out), 32'h1);
      rd(IDX_IRQ_FLAGS, 8'h80);
      rd(IDX_IRQ_FLAGS, 8'h00);
      wr(IDX_IRQ_UNMASK, 8'h80);
      pulse(3'h1);
      rd(IDX_IRQ_FLAGS, 8'h00);
      wr(IDX_IRQ_UNMASK, 8'h82);
      pulse(3'h2);
      rd(IDX_IRQ_FLAGS, 8'h02);
      wr(IDX_IRQ_PORT_CTL, 8'h04);
      @(negedge core_clk);
      chk(32'(irq_out), 32'h1);
      pulse(3'h4);
      chk(32'(irq_out), 32'h0);
      wr(IDX_IRQ_PORT_CTL, 8'h08);
      @(negedge core_clk);
      chk(32'({irq_out, irq_oe}), 32'h1);
      rd(IDX_IRQ_FLAGS, 8'h80);
      wr(IDX_IRQ_MODE_LO, 8'h80);
      pulse(3'h4);
      rd(IDX_IRQ_FLAGS, 8'h80);
      wr(IDX_IRQ_MODE_HI, 8'h80);
      pulse(3'h4);
      rd(IDX_IRQ_FLAGS, 8'h00);
      wr(IDX_IRQ_MODE_LO, 8'h00);
      pulse(3'h4);
      rd(IDX_IRQ_FLAGS, 8'h80);
      $display("interrupt tests done");
      report_and_stop;
   end
endmodule : test_codec_mix_gain_irq_regs
